// file: inc/chf_pkg.sv
package chf_pkg;

  // ****************************************************************
  // Bus geometry and register map
  // ****************************************************************
  localparam int AXI_AW = 32;
  localparam int AXI_DW = 32;
  localparam int AXI_SW = AXI_DW / 8;
  localparam logic [AXI_AW-1:0] ADDR_FREEZE_SET = 32'h5005_0300;
  localparam logic [AXI_AW-1:0] ADDR_FREEZE_CLR = 32'h5005_0304;
  localparam logic [AXI_AW-1:0] ADDR_DEBUG_CTRL = 32'h5005_0308;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ****************************************************************
  // Freeze set and clear fields
  // ****************************************************************
  localparam int FRZ_W = 11;
  localparam logic [FRZ_W-1:0] FRZ_VALID_MASK = 11'h76f;
  localparam logic [FRZ_W-1:0] FRZ_RESET = 11'h000;
  localparam int FRZ_WAKEUP_TIMER_HOLD = 0;
  localparam int FRZ_SW_TIMER = 1;
  localparam int FRZ_SPARE = 2;
  localparam int FRZ_SYS_WDOG = 3;
  localparam int FRZ_DMA = 5;
  localparam int FRZ_TIMER2 = 6;
  localparam int FRZ_TIMER3 = 8;
  localparam int FRZ_TIMER4 = 9;
  localparam int FRZ_RADIO_WDOG = 10;

  // ****************************************************************
  // Debug halt and freeze control fields
  // ****************************************************************
  localparam int DBG_W = 9;
  localparam logic [DBG_W-1:0] DBG_RESET = 9'h101;
  localparam logic [DBG_W-1:0] DBG_RW_MASK = 9'h1cf;
  localparam int DBG_HALT_PULSE_MODE = 8;
  localparam int DBG_STALL_DEBUG_WAKE = 7;
  localparam int DBG_STALL_WAKE = 6;
  localparam int DBG_RADIO_HALTED = 5;
  localparam int DBG_APP_HALTED = 4;
  localparam int DBG_RADIO_TO_APP_EN = 3;
  localparam int DBG_APP_TO_RADIO_EN = 2;
  localparam int DBG_RADIO_FREEZE_EN = 1;
  localparam int DBG_APP_FREEZE_EN = 0;

  // ****************************************************************
  // Wake and stall sequencing
  // ****************************************************************
  typedef enum logic [2:0] {
    ST_RUN = 3'b001,
    ST_SLEEP = 3'b010,
    ST_STALL = 3'b100
  } chf_wake_state_t;

endpackage

// file: src/chf_sync2.sv
module chf_sync2 #(
  parameter int W = 1
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] meta_q;

  // ****************************************************************
  // Two-stage synchroniser; the first stage feeds only the second.
  // ****************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_q <= '0;
      sync_out <= '0;
    end else begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule

// file: src/chf_halt_link.sv
module chf_halt_link (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic src_halted,
  input wire logic enable,
  input wire logic pulse_mode,
  output logic halt_req_q
);
  logic src_prev_q;

  // ****************************************************************
  // Passes a halt from one core to the other as a level or a pulse.
  // ****************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      src_prev_q <= 1'b0;
      halt_req_q <= 1'b0;
    end else begin
      src_prev_q <= src_halted;
      if (pulse_mode) begin
        halt_req_q <= enable & src_halted & ~src_prev_q;
      end else begin
        halt_req_q <= enable & src_halted;
      end
    end
  end
endmodule

// file: src/chf_top.sv
// What this block does
// - Writing 1 to wake-up timer clear bit unfreezes it; writing 0 does nothing.
// - Control bit 8 picks level (0) or pulse (1) halt passing; resets to 1.
// - Bit 7 stalls the application core out of reset after debug-caused wake-ups.
// - Debug-wake stall ignores sequencer setup; debug activity in sleep triggers it.
// - Bit 6 stalls the application core out of reset after every wake-up.
// - Debugger access continues while stalled; clearing the stall bit resumes the core.
// - Bit 5 reads 1 while the radio core is halted; resets to 0.
// - Bit 3 set passes radio-core halts to the application core.
// - Bit 2 set passes application-core halts to the radio core.
// - Radio freeze enable lets a radio-core halt freeze the covered peripherals.
// - Application freeze enable resets to 1 and freezes peripherals during halt.
// - With application freeze enable 0, an application-core halt freezes only the system watchdog beyond the freeze registers.
// - System watchdog always freezes while the application core is halted.
// - Control bits keep their values through deep sleep.
// - Writing 1 to a freeze set bit freezes that peripheral, the system watchdog only while wdog_nmi_select is 0; 0 ignored.
module chf_top (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [chf_pkg::AXI_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [chf_pkg::AXI_DW-1:0] s_axi_wdata,
  input wire logic [chf_pkg::AXI_SW-1:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [chf_pkg::AXI_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [chf_pkg::AXI_DW-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic app_core_halted,
  input wire logic radio_core_halted,
  input wire logic deep_sleep,
  input wire logic debug_activity,
  input wire logic wdog_nmi_select,
  output logic app_core_halt_req,
  output logic radio_core_halt_req,
  output logic app_core_stall,
  output logic [chf_pkg::FRZ_W-1:0] freeze_out
);
  import chf_pkg::*;

  logic [AXI_AW-1:0] aw_addr_q;
  logic aw_hold_q;
  logic [AXI_DW-1:0] w_data_q;
  logic [AXI_SW-1:0] w_strb_q;
  logic w_hold_q;
  logic do_write;
  logic [15:0] wr_mask;
  logic [15:0] wr_bits;
  logic [FRZ_W-1:0] freeze_reg_q;
  logic [DBG_W-1:0] dbg_q;
  logic [3:0] sync_s;
  logic app_halted_s;
  logic radio_halted_s;
  logic deep_sleep_s;
  logic debug_activity_s;
  chf_wake_state_t state_q;
  chf_wake_state_t state_d;
  logic dbg_seen_q;
  logic stall_hold;
  logic halt_freeze;
  logic [FRZ_W-1:0] eff_reg;
  logic [FRZ_W-1:0] freeze_d;

  // ****************************************************************
  // Pin synchronisers and cross-core halt links
  // ****************************************************************
  chf_sync2 #(
    .W(4)
  ) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .async_in({debug_activity, deep_sleep, radio_core_halted, app_core_halted}),
    .sync_out(sync_s)
  );

  assign app_halted_s = sync_s[0];
  assign radio_halted_s = sync_s[1];
  assign deep_sleep_s = sync_s[2];
  assign debug_activity_s = sync_s[3];

  // Application-core halt forwarded to the radio core.
  chf_halt_link u_app_to_radio (
    .aclk(aclk),
    .aresetn(aresetn),
    .src_halted(app_halted_s),
    .enable(dbg_q[DBG_APP_TO_RADIO_EN]),
    .pulse_mode(dbg_q[DBG_HALT_PULSE_MODE]),
    .halt_req_q(radio_core_halt_req)
  );

  // Radio-core halt forwarded to the application core.
  chf_halt_link u_radio_to_app (
    .aclk(aclk),
    .aresetn(aresetn),
    .src_halted(radio_halted_s),
    .enable(dbg_q[DBG_RADIO_TO_APP_EN]),
    .pulse_mode(dbg_q[DBG_HALT_PULSE_MODE]),
    .halt_req_q(app_core_halt_req)
  );

  // ****************************************************************
  // AXI4-Lite write channels
  // ****************************************************************
  assign do_write = aw_hold_q & w_hold_q & ~s_axi_bvalid;
  assign wr_mask = {{8{w_strb_q[1]}}, {8{w_strb_q[0]}}};
  assign wr_bits = w_data_q[15:0] & wr_mask;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_q <= 1'b0;
      aw_addr_q <= '0;
      s_axi_awready <= 1'b1;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_hold_q <= 1'b1;
      aw_addr_q <= s_axi_awaddr;
      s_axi_awready <= 1'b0;
    end else if (do_write) begin
      aw_hold_q <= 1'b0;
      s_axi_awready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_hold_q <= 1'b0;
      w_data_q <= '0;
      w_strb_q <= '0;
      s_axi_wready <= 1'b1;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_hold_q <= 1'b1;
      w_data_q <= s_axi_wdata;
      w_strb_q <= s_axi_wstrb;
      s_axi_wready <= 1'b0;
    end else if (do_write) begin
      w_hold_q <= 1'b0;
      s_axi_wready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      if (aw_addr_q == ADDR_FREEZE_SET || aw_addr_q == ADDR_FREEZE_CLR || aw_addr_q == ADDR_DEBUG_CTRL) begin
        s_axi_bresp <= RESP_OKAY;
      end else begin
        s_axi_bresp <= RESP_SLVERR;
      end
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ****************************************************************
  // Freeze register and debug control register
  // ****************************************************************
  // Only aresetn resets these; deep sleep leaves them untouched.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      freeze_reg_q <= FRZ_RESET;
    end else if (do_write && aw_addr_q == ADDR_FREEZE_SET) begin
      freeze_reg_q <= freeze_reg_q | (wr_bits[FRZ_W-1:0] & FRZ_VALID_MASK);
    end else if (do_write && aw_addr_q == ADDR_FREEZE_CLR) begin
      freeze_reg_q <= freeze_reg_q & ~(wr_bits[FRZ_W-1:0] & FRZ_VALID_MASK);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dbg_q <= DBG_RESET;
    end else if (do_write && aw_addr_q == ADDR_DEBUG_CTRL) begin
      dbg_q <= (dbg_q & ~(wr_mask[DBG_W-1:0] & DBG_RW_MASK)) | (wr_bits[DBG_W-1:0] & DBG_RW_MASK);
    end
  end

  // ****************************************************************
  // AXI4-Lite read channels
  // ****************************************************************
  function automatic logic [AXI_DW-1:0] read_word(input logic [AXI_AW-1:0] addr);
    logic [AXI_DW-1:0] word;
    word = '0;
    if (addr == ADDR_FREEZE_SET || addr == ADDR_FREEZE_CLR) begin
      word[FRZ_W-1:0] = freeze_reg_q;
    end else if (addr == ADDR_DEBUG_CTRL) begin
      word[DBG_W-1:0] = dbg_q & DBG_RW_MASK;
      word[DBG_RADIO_HALTED] = radio_halted_s;
      word[DBG_APP_HALTED] = app_halted_s;
    end
    return word;
  endfunction

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= read_word(s_axi_araddr);
      if (s_axi_araddr == ADDR_FREEZE_SET || s_axi_araddr == ADDR_FREEZE_CLR ||
          s_axi_araddr == ADDR_DEBUG_CTRL) begin
        s_axi_rresp <= RESP_OKAY;
      end else begin
        s_axi_rresp <= RESP_SLVERR;
      end
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // ****************************************************************
  // Wake-up stall sequencing
  // ****************************************************************
  // The stall only gates instruction fetch in the core; the debug path and this bus stay live.
  assign stall_hold = dbg_q[DBG_STALL_WAKE] | (dbg_q[DBG_STALL_DEBUG_WAKE] & dbg_seen_q);

  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_RUN: begin
        if (deep_sleep_s) begin
          state_d = ST_SLEEP;
        end
      end
      ST_SLEEP: begin
        if (!deep_sleep_s) begin
          if (dbg_q[DBG_STALL_WAKE] || (dbg_q[DBG_STALL_DEBUG_WAKE] && (dbg_seen_q || debug_activity_s))) begin
            state_d = ST_STALL;
          end else begin
            state_d = ST_RUN;
          end
        end
      end
      ST_STALL: begin
        if (deep_sleep_s) begin
          state_d = ST_SLEEP;
        end else if (!stall_hold) begin
          state_d = ST_RUN;
        end
      end
      default: begin
        state_d = ST_RUN;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= ST_RUN;
      app_core_stall <= 1'b0;
    end else begin
      state_q <= state_d;
      app_core_stall <= (state_d == ST_STALL);
    end
  end

  // Debug activity is seen regardless of which domains the sequencer powers.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dbg_seen_q <= 1'b0;
    end else if (state_q != ST_SLEEP && deep_sleep_s) begin
      dbg_seen_q <= 1'b0;
    end else if (state_q == ST_SLEEP && debug_activity_s) begin
      dbg_seen_q <= 1'b1;
    end
  end

  // ****************************************************************
  // Peripheral freeze outputs
  // ****************************************************************
  assign halt_freeze = (app_halted_s & dbg_q[DBG_APP_FREEZE_EN]) | (radio_halted_s & dbg_q[DBG_RADIO_FREEZE_EN]);

  always_comb begin
    eff_reg = freeze_reg_q;
    eff_reg[FRZ_SYS_WDOG] = freeze_reg_q[FRZ_SYS_WDOG] & ~wdog_nmi_select;
    freeze_d = (eff_reg | {FRZ_W{halt_freeze}}) & FRZ_VALID_MASK;
    freeze_d[FRZ_SYS_WDOG] = freeze_d[FRZ_SYS_WDOG] | app_halted_s;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      freeze_out <= '0;
    end else begin
      freeze_out <= freeze_d;
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  property p_wake_timer_release;
    do_write && aw_addr_q == ADDR_FREEZE_CLR && w_strb_q[0] && w_data_q[FRZ_WAKEUP_TIMER_HOLD]
      |=> !freeze_reg_q[FRZ_WAKEUP_TIMER_HOLD];
  endproperty
  a_wake_timer_release: assert property (p_wake_timer_release) else $error("wake-up timer still frozen");

  property p_set_freezes;
    do_write && aw_addr_q == ADDR_FREEZE_SET && w_strb_q[0] && w_data_q[FRZ_DMA]
      |=> freeze_reg_q[FRZ_DMA] ##1 freeze_out[FRZ_DMA];
  endproperty
  a_set_freezes: assert property (p_set_freezes) else $error("freeze set did not freeze");

  property p_pulse_halt;
    dbg_q[DBG_HALT_PULSE_MODE] && radio_core_halt_req |=> !radio_core_halt_req;
  endproperty
  a_pulse_halt: assert property (p_pulse_halt) else $error("pulse halt longer than one cycle");

  property p_no_radio_to_app;
    !dbg_q[DBG_RADIO_TO_APP_EN] |=> !app_core_halt_req;
  endproperty
  a_no_radio_to_app: assert property (p_no_radio_to_app) else $error("halt passed while disabled");

  property p_level_app_to_radio;
    !dbg_q[DBG_HALT_PULSE_MODE] && dbg_q[DBG_APP_TO_RADIO_EN] && app_halted_s
      ##1 !dbg_q[DBG_HALT_PULSE_MODE] |-> radio_core_halt_req;
  endproperty
  a_level_app_to_radio: assert property (p_level_app_to_radio) else $error("app halt not passed");

  property p_wake_stall;
    state_q == ST_SLEEP && !deep_sleep_s && dbg_q[DBG_STALL_WAKE] |=> app_core_stall [*2];
  endproperty
  a_wake_stall: assert property (p_wake_stall) else $error("no stall after wake");

  property p_debug_wake_stall;
    state_q == ST_SLEEP && !deep_sleep_s && dbg_q[DBG_STALL_DEBUG_WAKE] && dbg_seen_q |=> app_core_stall;
  endproperty
  a_debug_wake_stall: assert property (p_debug_wake_stall) else $error("no stall after debug wake");

  property p_stall_release;
    app_core_stall && !dbg_q[DBG_STALL_WAKE] && !dbg_q[DBG_STALL_DEBUG_WAKE] |-> ##[1:2] !app_core_stall;
  endproperty
  a_stall_release: assert property (p_stall_release) else $error("core not released");

  property p_wdog_always;
    app_halted_s |=> freeze_out[FRZ_SYS_WDOG];
  endproperty
  a_wdog_always: assert property (p_wdog_always) else $error("watchdog not frozen on halt");

  property p_reg_only;
    !dbg_q[DBG_APP_FREEZE_EN] && !dbg_q[DBG_RADIO_FREEZE_EN] && !app_halted_s && !wdog_nmi_select
      |=> freeze_out == ($past(freeze_reg_q) & FRZ_VALID_MASK);
  endproperty
  a_reg_only: assert property (p_reg_only) else $error("freeze not from registers only");

  property p_halt_flag_read;
    s_axi_arvalid && s_axi_arready && s_axi_araddr == ADDR_DEBUG_CTRL
      |=> s_axi_rvalid && s_axi_rdata[DBG_RADIO_HALTED] == $past(radio_halted_s);
  endproperty
  a_halt_flag_read: assert property (p_halt_flag_read) else $error("radio halted flag wrong");

  c_stall: cover property (state_q == ST_SLEEP ##1 state_q == ST_STALL);
  c_pulse: cover property (dbg_q[DBG_HALT_PULSE_MODE] && app_core_halt_req);
  c_halt_freeze: cover property (radio_halted_s && dbg_q[DBG_RADIO_FREEZE_EN] ##1 freeze_out[FRZ_DMA]);
  c_slverr: cover property (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
endmodule

// file: verif/chf_core_model.sv
module chf_core_model (
  input wire logic aclk,
  input wire logic app_halt_req,
  input wire logic radio_halt_req,
  input wire logic app_dbg_halt,
  input wire logic radio_dbg_halt,
  input wire logic resume,
  output logic app_core_halted,
  output logic radio_core_halted
);
  timeunit 1ns;
  timeprecision 1ns;

  logic app_hold_q;
  logic radio_hold_q;

  // ****************************************************************
  // Two cores that stop on a forwarded halt until the debugger resumes
  // ****************************************************************
  always_ff @(posedge aclk) begin
    if (app_halt_req) begin
      app_hold_q <= 1'b1;
    end else if (resume) begin
      app_hold_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (radio_halt_req) begin
      radio_hold_q <= 1'b1;
    end else if (resume) begin
      radio_hold_q <= 1'b0;
    end
  end

  assign app_core_halted = app_dbg_halt | app_hold_q;
  assign radio_core_halted = radio_dbg_halt | radio_hold_q;
endmodule

// file: verif/chf_top_test.sv
`define CHK(nm, ex, got) begin total_checks++; if ((got) !== (ex)) begin miscompares++; \
  $display("[FAIL] %s expected %0h seen %0h", nm, ex, got); end end

module chf_top_test;
  timeunit 1ns;
  timeprecision 1ns;
  import chf_pkg::*;

  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] wdata;
    logic [1:0] resp;
    logic [31:0] rd;
    logic [10:0] frz;
  } chf_row_t;

  localparam chf_row_t ROWS [9] = '{
    '{ADDR_FREEZE_SET, 32'h0000_07ff, RESP_OKAY, 32'h0000_076f, 11'h76f},
    '{ADDR_FREEZE_CLR, 32'h0000_0001, RESP_OKAY, 32'h0000_076e, 11'h76e},
    '{ADDR_FREEZE_CLR, 32'h0000_0000, RESP_OKAY, 32'h0000_076e, 11'h76e},
    '{ADDR_FREEZE_SET, 32'h0000_0000, RESP_OKAY, 32'h0000_076e, 11'h76e},
    '{ADDR_FREEZE_CLR, 32'h0000_07ff, RESP_OKAY, 32'h0000_0000, 11'h000},
    '{ADDR_FREEZE_SET, 32'h0000_0008, RESP_OKAY, 32'h0000_0008, 11'h008},
    '{ADDR_DEBUG_CTRL, 32'hffff_ffff, RESP_OKAY, 32'h0000_01cf, 11'h008},
    '{ADDR_DEBUG_CTRL, 32'h0000_0000, RESP_OKAY, 32'h0000_0000, 11'h008},
    '{32'h5005_030c, 32'hffff_ffff, RESP_SLVERR, 32'h0000_0000, 11'h008}
  };

  logic aclk;
  logic aresetn;
  logic [31:0] s_axi_awaddr;
  logic s_axi_awvalid;
  logic s_axi_awready;
  logic [31:0] s_axi_wdata;
  logic [3:0] s_axi_wstrb;
  logic s_axi_wvalid;
  logic s_axi_wready;
  logic [1:0] s_axi_bresp;
  logic s_axi_bvalid;
  logic s_axi_bready;
  logic [31:0] s_axi_araddr;
  logic s_axi_arvalid;
  logic s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0] s_axi_rresp;
  logic s_axi_rvalid;
  logic s_axi_rready;
  logic app_core_halted;
  logic radio_core_halted;
  logic deep_sleep;
  logic debug_activity;
  logic wdog_nmi_select;
  logic app_core_halt_req;
  logic radio_core_halt_req;
  logic app_core_stall;
  logic [10:0] freeze_out;
  logic app_dbg;
  logic radio_dbg;
  logic resume;
  logic [1:0] resp;
  int miscompares = 0;
  int total_checks = 0;
  int n;

  chf_top dut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .app_core_halted(app_core_halted), .radio_core_halted(radio_core_halted),
    .deep_sleep(deep_sleep), .debug_activity(debug_activity), .wdog_nmi_select(wdog_nmi_select),
    .app_core_halt_req(app_core_halt_req), .radio_core_halt_req(radio_core_halt_req),
    .app_core_stall(app_core_stall), .freeze_out(freeze_out)
  );

  chf_core_model cores (
    .aclk(aclk), .app_halt_req(app_core_halt_req), .radio_halt_req(radio_core_halt_req),
    .app_dbg_halt(app_dbg), .radio_dbg_halt(radio_dbg), .resume(resume),
    .app_core_halted(app_core_halted), .radio_core_halted(radio_core_halted)
  );

  // ****************************************************************
  // Bus master and helpers
  // ****************************************************************
  task automatic tick(input int c);
    repeat (c) @(posedge aclk);
  endtask

  task automatic axi_wr(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw_ok;
    logic w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (!w_ok && s_axi_wready === 1'b1) begin
        w_ok = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
      if (!aw_ok && s_axi_awready === 1'b1) begin
        aw_ok = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
    end while (!(aw_ok && w_ok && s_axi_bvalid === 1'b1));
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic chk_rd(input logic [31:0] a, input logic [31:0] e, input logic [1:0] er);
    logic ar_ok;
    ar_ok = 1'b0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (!ar_ok && s_axi_arready === 1'b1) begin
        ar_ok = 1'b1;
        s_axi_arvalid <= 1'b0;
      end
    end while (!(ar_ok && s_axi_rvalid === 1'b1));
    `CHK("rdata", e, s_axi_rdata)
    `CHK("rresp", er, s_axi_rresp)
    s_axi_rready <= 1'b0;
  endtask

  task automatic wr_dbg(input logic [31:0] d);
    axi_wr(ADDR_DEBUG_CTRL, d, resp);
  endtask

  task automatic wake(input logic act);
    deep_sleep <= 1'b1;
    tick(6);
    debug_activity <= act;
    tick(3);
    debug_activity <= 1'b0;
    tick(3);
    deep_sleep <= 1'b0;
    tick(6);
  endtask

  task automatic release_cores();
    tick(6);
    resume <= 1'b1;
    tick(1);
    resume <= 1'b0;
    tick(5);
  endtask

  task automatic finish_test();
    if (miscompares == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end

  initial begin
    repeat (20000) @(posedge aclk);
    miscompares++;
    finish_test();
  end

  // ****************************************************************
  // Test sequence
  // ****************************************************************
  initial begin
    aresetn <= 1'b0;
    s_axi_awaddr <= '0;
    s_axi_awvalid <= 1'b0;
    s_axi_wdata <= '0;
    s_axi_wstrb <= 4'hf;
    s_axi_wvalid <= 1'b0;
    s_axi_bready <= 1'b0;
    s_axi_araddr <= '0;
    s_axi_arvalid <= 1'b0;
    s_axi_rready <= 1'b0;
    deep_sleep <= 1'b0;
    debug_activity <= 1'b0;
    wdog_nmi_select <= 1'b0;
    app_dbg <= 1'b0;
    radio_dbg <= 1'b0;
    resume <= 1'b1;
    tick(3);
    aresetn <= 1'b1;
    resume <= 1'b0;
    foreach (ROWS[i]) begin
      axi_wr(ROWS[i].addr, ROWS[i].wdata, resp);
      `CHK("bresp", ROWS[i].resp, resp)
      chk_rd(ROWS[i].addr, ROWS[i].rd, ROWS[i].resp);
      `CHK("freeze_out", ROWS[i].frz, freeze_out)
    end
    s_axi_wstrb <= 4'h2;
    axi_wr(ADDR_FREEZE_SET, 32'h0000_07ff, resp);
    s_axi_wstrb <= 4'hf;
    chk_rd(ADDR_FREEZE_SET, 32'h0000_0708, RESP_OKAY);
    axi_wr(ADDR_FREEZE_CLR, 32'h0000_0700, resp);
    wdog_nmi_select <= 1'b1;
    tick(4);
    `CHK("wdog_masked", 11'h000, freeze_out)
    wdog_nmi_select <= 1'b0;
    axi_wr(ADDR_FREEZE_CLR, 32'h0000_0008, resp);
    app_dbg <= 1'b1;
    tick(6);
    `CHK("wdog_only", 11'h008, freeze_out)
    `CHK("no_radio_req", 1'b0, radio_core_halt_req)
    chk_rd(ADDR_DEBUG_CTRL, 32'h0000_0010, RESP_OKAY);
    wr_dbg(32'h0000_0001);
    tick(4);
    `CHK("app_freeze", 11'h76f, freeze_out)
    wr_dbg(32'h0000_0004);
    tick(6);
    `CHK("radio_req", 1'b1, radio_core_halt_req)
    `CHK("freeze_en_off", 11'h008, freeze_out)
    chk_rd(ADDR_DEBUG_CTRL, 32'h0000_0034, RESP_OKAY);
    app_dbg <= 1'b0;
    release_cores();
    chk_rd(ADDR_DEBUG_CTRL, 32'h0000_0004, RESP_OKAY);
    wr_dbg(32'h0000_000a);
    radio_dbg <= 1'b1;
    tick(6);
    `CHK("app_req", 1'b1, app_core_halt_req)
    `CHK("radio_freeze", 11'h76f, freeze_out)
    radio_dbg <= 1'b0;
    release_cores();
    wr_dbg(32'h0000_010c);
    radio_dbg <= 1'b1;
    n = 0;
    repeat (12) begin
      @(posedge aclk);
      if (app_core_halt_req === 1'b1) n++;
    end
    `CHK("pulse_len", 1, n)
    radio_dbg <= 1'b0;
    release_cores();
    // Both halt enables stay clear across every sleep below.
    wr_dbg(32'h0000_0140);
    wake(1'b0);
    `CHK("stall_any", 1'b1, app_core_stall)
    chk_rd(ADDR_DEBUG_CTRL, 32'h0000_0140, RESP_OKAY);
    wr_dbg(32'h0000_0100);
    tick(3);
    `CHK("stall_off", 1'b0, app_core_stall)
    wr_dbg(32'h0000_0180);
    wake(1'b0);
    `CHK("no_dbg_wake", 1'b0, app_core_stall)
    wake(1'b1);
    `CHK("dbg_wake", 1'b1, app_core_stall)
    wr_dbg(32'h0000_0100);
    tick(3);
    `CHK("dbg_stall_off", 1'b0, app_core_stall)
    wr_dbg(32'h0000_00cf);
    aresetn <= 1'b0;
    tick(3);
    aresetn <= 1'b1;
    tick(2);
    `CHK("rst_freeze", 11'h000, freeze_out)
    chk_rd(ADDR_DEBUG_CTRL, 32'h0000_0101, RESP_OKAY);
    chk_rd(ADDR_FREEZE_SET, 32'h0000_0000, RESP_OKAY);
    finish_test();
  end
endmodule
